// [src/ovr_pkg.sv]
// shared constants and types for the over-voltage response and configuration block
package ovr_pkg;
    // ==========================================================
    // command codes of the setting words
    localparam logic [7:0] CMD_OUT_FORMAT = 8'h20;
    localparam logic [7:0] CMD_DUTY_CEILING = 8'h32;
    localparam logic [7:0] CMD_SW_FREQ = 8'h33;
    localparam logic [7:0] CMD_INPUT_TURN_ON_LEVEL = 8'h35;
    localparam logic [7:0] CMD_INPUT_TURN_OFF_LEVEL = 8'h36;
    localparam logic [7:0] CMD_PHASE_SPREAD = 8'h37;
    localparam logic [7:0] CMD_CUR_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
    localparam logic [7:0] CMD_OV_ACTION = 8'h41;
    localparam logic [7:0] CMD_TIME_UNIT = 8'hc8;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_DUTY_CEILING = 16'h0000;
    localparam logic [15:0] RST_SW_FREQ = 16'h0000;
    localparam logic [15:0] RST_INPUT_TURN_ON_LEVEL = 16'h0000;
    localparam logic [15:0] RST_INPUT_TURN_OFF_LEVEL = 16'h0000;
    localparam logic [15:0] RST_PHASE_SPREAD = 16'h0000;
    localparam logic [15:0] RST_CUR_OFFSET = 16'h0000;
    localparam logic [15:0] RST_OV_LIMIT = 16'hffff;
    localparam logic [7:0] RST_OV_ACTION = 8'h80;
    localparam logic [15:0] RST_TIME_UNIT = 16'h0001;

    // ==========================================================
    // field positions
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam int GRP_HI = 11;
    localparam int GRP_LO = 8;
    localparam int CNT_HI = 7;
    localparam int CNT_LO = 4;
    localparam int POS_HI = 3;
    localparam int POS_LO = 0;
    localparam int MANT_HI = 10;

    // ==========================================================
    // encodings
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_DELAY = 2'h1;
    localparam logic [1:0] RESP_DISABLE = 2'h2;
    localparam logic [1:0] RESP_HOLD = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // linear output format, exponent -11
    localparam logic [7:0] OUT_FORMAT_VAL = 8'h15;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 20;
    localparam int UNIT_US = 1;
    localparam int CYC_PER_UNIT_US = UNIT_US * CLK_MHZ;

    typedef struct packed {
        logic wr;
        logic [7:0] code;
        logic [15:0] wdata;
    } ovr_cmd_t;

    typedef struct packed {
        logic [3:0] group_id;
        logic [3:0] rail_count;
        logic [3:0] rail_pos;
    } ovr_phase_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_DELAY,
        ST_WAIT,
        ST_LATCH,
        ST_HOLD
    } ovr_state_t;
endpackage

// [src/ovr_core.sv]
// over-voltage fault response, input thresholds and setting words of the power stage
`timescale 1ns/1ns
module ovr_core
#(
    parameter int CYC_PER_US = ovr_pkg::CYC_PER_UNIT_US
)
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic clk_link_in,
    input wire logic rst_link_in,
    input wire logic lk_req_in,
    input wire ovr_pkg::ovr_cmd_t lk_cmd_in,
    output logic lk_ready_out,
    output logic lk_done_out,
    output logic lk_ack_out,
    output logic [15:0] lk_rdata_out,
    input wire logic [15:0] vout_meas_in,
    input wire logic [15:0] vin_meas_in,
    input wire logic [15:0] output_current_raw_in,
    input wire logic ctrl_pin_in,
    input wire logic operation_on_in,
    input wire logic status_clear_in,
    input wire logic clear_faults_in,
    output logic output_enable_out,
    output logic ov_fault_flag_out,
    output logic [15:0] output_current_reading_out,
    output logic [15:0] duty_ceiling_out,
    output logic [15:0] sw_freq_khz_out,
    output ovr_pkg::ovr_phase_t phase_out
);
    import ovr_pkg::*;

    // ==========================================================
    // link side: command capture and answer
    logic busy_q;
    logic req_tgl_q;
    ovr_cmd_t hold_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic done_q;
    logic ok_lk_q;
    logic [15:0] rdata_lk_q;
    logic ack_tgl_q;
    logic ans_ok_q;
    logic [15:0] ans_data_q;
    wire lk_take = lk_req_in && !busy_q;
    wire ack_seen = ack_s2_q != ack_s3_q;

    assign lk_ready_out = !busy_q;
    assign lk_done_out = done_q;
    assign lk_ack_out = ok_lk_q;
    assign lk_rdata_out = rdata_lk_q;

    always_ff @(posedge clk_link_in)
    begin
        if (rst_link_in)
        begin
            busy_q <= 1'b0;
            req_tgl_q <= 1'b0;
            hold_q <= '0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
            done_q <= 1'b0;
            ok_lk_q <= 1'b0;
            rdata_lk_q <= '0;
        end
        else
        begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            done_q <= ack_seen;
            if (lk_take)
            begin
                hold_q <= lk_cmd_in;
                req_tgl_q <= !req_tgl_q;
                busy_q <= 1'b1;
            end
            else if (ack_seen)
            begin
                busy_q <= 1'b0;
                ok_lk_q <= ans_ok_q;
                rdata_lk_q <= ans_data_q;
            end
        end
    end

    // ==========================================================
    // system side: request synchroniser and register file
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic [15:0] duty_q;
    logic [15:0] freq_q;
    logic [15:0] von_q;
    logic [15:0] voff_q;
    logic [15:0] phase_q;
    logic [15:0] ioff_q;
    logic [15:0] ovlim_q;
    logic [7:0] action_q;
    logic [15:0] unit_q;
    wire req_new = req_s2_q != req_s3_q;
    wire acc = req_new && ce_in;
    wire wr_acc = acc && hold_q.wr;

    logic hit;
    logic [15:0] rd_mux;
    always_comb
    begin
        hit = 1'b1;
        rd_mux = '0;
        unique case (hold_q.code)
            CMD_OUT_FORMAT: rd_mux = {8'h00, OUT_FORMAT_VAL};
            CMD_DUTY_CEILING: rd_mux = duty_q;
            CMD_SW_FREQ: rd_mux = freq_q;
            CMD_INPUT_TURN_ON_LEVEL: rd_mux = von_q;
            CMD_INPUT_TURN_OFF_LEVEL: rd_mux = voff_q;
            CMD_PHASE_SPREAD: rd_mux = phase_q;
            CMD_CUR_OFFSET: rd_mux = ioff_q;
            CMD_OV_LIMIT: rd_mux = ovlim_q;
            CMD_OV_ACTION: rd_mux = {8'h00, action_q};
            CMD_TIME_UNIT: rd_mux = unit_q;
            default: hit = 1'b0;
        endcase
    end
    // the format word is fixed, so writing it is refused
    wire wr_ok = hit && (hold_q.code != CMD_OUT_FORMAT);

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end
        else if (ce_in)
        begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ack_tgl_q <= 1'b0;
            ans_ok_q <= 1'b0;
            ans_data_q <= '0;
        end
        else if (acc)
        begin
            ack_tgl_q <= !ack_tgl_q;
            ans_ok_q <= hold_q.wr ? wr_ok : hit;
            ans_data_q <= hold_q.wr ? 16'h0000 : rd_mux;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            duty_q <= RST_DUTY_CEILING;
            freq_q <= RST_SW_FREQ;
            von_q <= RST_INPUT_TURN_ON_LEVEL;
            voff_q <= RST_INPUT_TURN_OFF_LEVEL;
            phase_q <= RST_PHASE_SPREAD;
            ioff_q <= RST_CUR_OFFSET;
            ovlim_q <= RST_OV_LIMIT;
            action_q <= RST_OV_ACTION;
            unit_q <= RST_TIME_UNIT;
        end
        else if (wr_acc && wr_ok)
        begin
            if (hold_q.code == CMD_DUTY_CEILING) duty_q <= hold_q.wdata;
            if (hold_q.code == CMD_SW_FREQ) freq_q <= hold_q.wdata;
            if (hold_q.code == CMD_INPUT_TURN_ON_LEVEL) von_q <= hold_q.wdata;
            if (hold_q.code == CMD_INPUT_TURN_OFF_LEVEL) voff_q <= hold_q.wdata;
            if (hold_q.code == CMD_PHASE_SPREAD) phase_q <= hold_q.wdata;
            if (hold_q.code == CMD_CUR_OFFSET) ioff_q <= hold_q.wdata;
            if (hold_q.code == CMD_OV_LIMIT) ovlim_q <= hold_q.wdata;
            if (hold_q.code == CMD_OV_ACTION) action_q <= hold_q.wdata[7:0];
            if (hold_q.code == CMD_TIME_UNIT) unit_q <= hold_q.wdata;
        end
    end

    // ==========================================================
    // setting outputs
    assign duty_ceiling_out = duty_q;
    assign sw_freq_khz_out = freq_q;
    assign phase_out.group_id = phase_q[GRP_HI:GRP_LO];
    assign phase_out.rail_count = phase_q[CNT_HI:CNT_LO];
    assign phase_out.rail_pos = phase_q[POS_HI:POS_LO];

    // offset mantissa added to raw mantissa, raw exponent kept
    logic [15:0] output_current_reading_q;
    wire [10:0] output_current_reading_sum = output_current_raw_in[MANT_HI:0] + ioff_q[MANT_HI:0];
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            output_current_reading_q <= '0;
        else if (ce_in)
            output_current_reading_q <= {output_current_raw_in[15:MANT_HI+1], output_current_reading_sum};
    end
    assign output_current_reading_out = output_current_reading_q;

    // ==========================================================
    // on/off command, input thresholds, fault detection
    logic pin_s1_q;
    logic pin_s2_q;
    logic run_q;
    logic conv_q;
    logic flag_q;
    wire run_now = pin_s2_q && operation_on_in;
    wire off_cmd = run_q && !run_now;
    wire ov_det = vout_meas_in > ovlim_q;
    wire clr_any = status_clear_in || clear_faults_in || off_cmd;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            run_q <= 1'b0;
            conv_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else if (ce_in)
        begin
            pin_s1_q <= ctrl_pin_in;
            pin_s2_q <= pin_s1_q;
            run_q <= run_now;
            if (!conv_q && vin_meas_in >= von_q)
                conv_q <= 1'b1;
            else if (conv_q && vin_meas_in <= voff_q)
                conv_q <= 1'b0;
            // a new detection wins over a clear in the same cycle
            if (ov_det)
                flag_q <= 1'b1;
            else if (clr_any)
                flag_q <= 1'b0;
        end
    end
    assign ov_fault_flag_out = flag_q;

    // ==========================================================
    // delay timer: microsecond prescale, time unit, 2^n units
    ovr_state_t st_q;
    ovr_state_t st_d;
    logic [15:0] pre_q;
    logic [15:0] us_q;
    logic [7:0] units_q;
    logic [2:0] tries_q;
    wire [1:0] resp = action_q[RESP_HI:RESP_LO];
    wire [2:0] retries = action_q[RETRY_HI:RETRY_LO];
    wire [2:0] dly = action_q[DELAY_HI:DELAY_LO];
    wire [7:0] units_tgt = 8'h01 << dly;
    wire [15:0] pre_last = 16'(CYC_PER_US - 1);
    wire [15:0] us_last = (unit_q == 16'h0000) ? 16'h0000 : unit_q - 16'h0001;
    wire us_tick = pre_q == pre_last;
    wire unit_tick = us_tick && (us_q == us_last);
    wire tmr_done = unit_tick && (units_q == units_tgt - 8'h01);
    wire tmr_run = (st_q == ST_DELAY) || (st_q == ST_WAIT);
    wire tmr_clr = !tmr_run || (st_d != st_q) || !run_now;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            pre_q <= '0;
            us_q <= '0;
            units_q <= '0;
        end
        else if (ce_in)
        begin
            if (tmr_clr)
            begin
                pre_q <= '0;
                us_q <= '0;
                units_q <= '0;
            end
            else
            begin
                pre_q <= us_tick ? 16'h0000 : pre_q + 16'h0001;
                if (us_tick)
                    us_q <= unit_tick ? 16'h0000 : us_q + 16'h0001;
                if (unit_tick)
                    units_q <= units_q + 8'h01;
            end
        end
    end

    // ==========================================================
    // fault response state machine
    wire tries_left = (retries == RETRY_FOREVER) || (tries_q < retries);
    wire give_up = (retries == RETRY_NONE) || !tries_left;
    wire cleared = status_clear_in || clear_faults_in;

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_RUN:
                if (ov_det)
                begin
                    unique case (resp)
                        RESP_IGNORE: st_d = ST_RUN;
                        RESP_DELAY: st_d = ST_DELAY;
                        RESP_DISABLE: st_d = give_up ? ST_LATCH : ST_WAIT;
                        RESP_HOLD: st_d = ST_HOLD;
                    endcase
                end
            ST_DELAY:
                if (!ov_det)
                    st_d = ST_RUN;
                else if (tmr_done)
                    st_d = give_up ? ST_LATCH : ST_WAIT;
            ST_WAIT:
                if (tmr_done)
                    st_d = ST_RUN;
            ST_LATCH:
                if (cleared && !ov_det)
                    st_d = ST_RUN;
            ST_HOLD:
                if (!ov_det)
                    st_d = ST_RUN;
            default: st_d = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            st_q <= ST_RUN;
            tries_q <= '0;
        end
        else if (ce_in)
        begin
            if (!run_now || cleared)
            begin
                st_q <= ST_RUN;
                tries_q <= '0;
            end
            else
            begin
                st_q <= st_d;
                if (st_q == ST_WAIT && st_d == ST_RUN && retries != RETRY_FOREVER)
                    tries_q <= tries_q + 3'h1;
            end
        end
    end

    wire fsm_en = (st_q == ST_RUN) || (st_q == ST_DELAY);
    logic oen_q;
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            oen_q <= 1'b0;
        else if (ce_in)
            oen_q <= run_now && conv_q && (st_d == ST_RUN || st_d == ST_DELAY);
    end
    assign output_enable_out = oen_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    AST_IGNORE_RUNS: assert property (
        ce_in && run_now && st_q == ST_RUN && ov_det && resp == RESP_IGNORE
        |=> st_q == ST_RUN)
        else $error("ignore response left run state");
    AST_DELAY_KEEPS_ON: assert property (
        ce_in && run_now && st_q == ST_DELAY && ov_det && !tmr_done && !cleared
        |=> st_q == ST_DELAY && fsm_en)
        else $error("delay response stopped early");
    AST_DISABLE_NOW: assert property (
        ce_in && run_now && !cleared && st_q == ST_RUN && ov_det && resp == RESP_DISABLE
        |=> !oen_q && !fsm_en)
        else $error("disable response did not turn output off");
    AST_HOLD_RELEASE: assert property (
        ce_in && run_now && st_q == ST_HOLD && !ov_det |=> st_q == ST_RUN)
        else $error("hold response did not resume");
    AST_FLAG_CLEAR: assert property (
        ce_in && clear_faults_in && !ov_det |=> !flag_q)
        else $error("fault flag not cleared");
    AST_FLAG_SET: assert property (
        ce_in && ov_det |=> flag_q)
        else $error("fault flag not set on detection");
    AST_NO_RETRY: assert property (
        ce_in && run_now && !cleared && st_q == ST_RUN && ov_det && resp == RESP_DISABLE
        && retries == RETRY_NONE |=> st_q == ST_LATCH)
        else $error("retry zero did not latch off");
    AST_LATCH_STAYS: assert property (
        ce_in && run_now && st_q == ST_LATCH && !cleared |=> st_q == ST_LATCH)
        else $error("latched fault left without clear");
    AST_TRIES_BOUND: assert property (
        ce_in && run_now && !cleared && retries != RETRY_FOREVER && st_q == ST_WAIT
        && st_d == ST_RUN |-> tries_q < retries)
        else $error("restart beyond retry setting");
    AST_WAIT_TIMED: assert property (
        ce_in && run_now && !cleared && st_q == ST_WAIT && !tmr_done |=> st_q == ST_WAIT)
        else $error("restart before spacing elapsed");
    AST_INPUT_TURN_OFF_LEVEL: assert property (
        ce_in && conv_q && vin_meas_in <= voff_q |=> !conv_q)
        else $error("conversion kept below turn-off level");
    AST_OFF_RESET: assert property (
        ce_in && !run_now |=> tries_q == 3'h0 && st_q == ST_RUN ##1 !ce_in || units_q == 8'h00)
        else $error("off command did not reset retry state");

    CV_LATCH: cover property (st_q == ST_WAIT ##[1:1000] st_q == ST_LATCH);
    CV_DELAY_END: cover property (st_q == ST_DELAY && tmr_done);
    CV_HOLD: cover property (st_q == ST_HOLD ##1 st_q == ST_RUN);
    CV_WRITE: cover property (wr_acc && wr_ok);
endmodule

// [dv/ovr_host_model.sv]
// host model of the command port: one transfer at a time
`timescale 1ns/1ns
module ovr_host_model
(
    input wire logic clk_link_in,
    input wire logic lk_ready_in,
    input wire logic lk_done_in,
    input wire logic lk_ack_in,
    input wire logic [15:0] lk_rdata_in,
    output logic lk_req_out,
    output ovr_pkg::ovr_cmd_t lk_cmd_out
);
    import ovr_pkg::*;
    initial
    begin
        lk_req_out = 1'b0;
        lk_cmd_out = '0;
    end
    // ==========================
    // request raised after ready is seen and held for one link clock edge only
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
        output logic ack, output logic [15:0] rdata);
        int n;
        n = 0;
        @(posedge clk_link_in);
        #1;
        while (!lk_ready_in && n < 400)
        begin
            @(posedge clk_link_in);
            #1;
            n++;
        end
        @(posedge clk_link_in);
        lk_req_out <= 1'b1;
        lk_cmd_out <= '{wr, code, wdata};
        @(posedge clk_link_in);
        lk_req_out <= 1'b0;
        // released lines carry junk, not the last command
        lk_cmd_out <= ~lk_cmd_out;
        n = 0;
        do
        begin
            @(posedge clk_link_in);
            #1;
            n++;
        end
        while (!lk_done_in && n < 400);
        ack = lk_ack_in;
        rdata = lk_rdata_in;
    endtask
endmodule

// [dv/ovr_core_bench.sv]
// self-checking bench of the over-voltage response block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ovr_core_bench;
    import ovr_pkg::*;
    typedef struct {logic [7:0] c; logic [15:0] d; logic a;} ovr_row_t;
    logic clk_sys_in = 1'b0;
    logic clk_link_in = 1'b0;
    logic rst_in = 1'b1;
    logic rst_link_in = 1'b1;
    logic ce_in = 1'b1;
    logic ctrl_pin_in = 1'b1;
    logic operation_on_in = 1'b1;
    logic status_clear_in = 1'b0;
    logic clear_faults_in = 1'b0;
    logic [15:0] vout_meas_in = 16'h1000;
    logic [15:0] vin_meas_in = 16'h0200;
    logic [15:0] output_current_raw_in = 16'hf80a;
    logic lk_req, lk_ready, lk_done, lk_ack, oen, flag, prev_oen;
    logic [15:0] lk_rdata, cur, duty, freq;
    ovr_cmd_t lk_cmd;
    ovr_phase_t phase;
    int err_total = 0;
    int n_tests = 0;
    int rises = 0;
    int lows = 0;
    int cyc = 0;
    // code, data, expected acknowledge
    ovr_row_t rows[9] = '{'{8'h32, 16'h1234, 1'b1}, '{8'h33, 16'h0190, 1'b1},
        '{8'h35, 16'h0100, 1'b1}, '{8'h36, 16'h0080, 1'b1}, '{8'h37, 16'h0a53, 1'b1},
        '{8'h39, 16'h0005, 1'b1}, '{8'h40, 16'h2000, 1'b1}, '{8'hc8, 16'h0001, 1'b1},
        '{8'h55, 16'hbeef, 1'b0}};
    initial forever #25 clk_sys_in = ~clk_sys_in;
    initial
    begin
        #7;
        forever #3 clk_link_in = ~clk_link_in;
    end
    ovr_core #(.CYC_PER_US(1)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .clk_link_in(clk_link_in),
        .rst_link_in(rst_link_in), .lk_req_in(lk_req), .lk_cmd_in(lk_cmd),
        .lk_ready_out(lk_ready), .lk_done_out(lk_done), .lk_ack_out(lk_ack),
        .lk_rdata_out(lk_rdata), .vout_meas_in(vout_meas_in), .vin_meas_in(vin_meas_in),
        .output_current_raw_in(output_current_raw_in), .ctrl_pin_in(ctrl_pin_in),
        .operation_on_in(operation_on_in), .status_clear_in(status_clear_in),
        .clear_faults_in(clear_faults_in), .output_enable_out(oen),
        .ov_fault_flag_out(flag), .output_current_reading_out(cur),
        .duty_ceiling_out(duty), .sw_freq_khz_out(freq), .phase_out(phase));
    ovr_host_model host_u (.clk_link_in(clk_link_in), .lk_ready_in(lk_ready),
        .lk_done_in(lk_done), .lk_ack_in(lk_ack), .lk_rdata_in(lk_rdata),
        .lk_req_out(lk_req), .lk_cmd_out(lk_cmd));
    // ==========================
    // enable watcher and hang limit
    always @(posedge clk_sys_in)
    begin
        prev_oen <= oen;
        rises <= rises + int'(oen && !prev_oen);
        lows <= lows + int'(!oen);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] c, input logic [15:0] d, input logic a);
        logic ack;
        logic [15:0] rd;
        host_u.xfer(1'b1, c, d, ack, rd);
        `CHK("wr_ack", a, ack)
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic a, input logic [15:0] d);
        logic ack;
        logic [15:0] rd;
        host_u.xfer(1'b0, c, 16'h0000, ack, rd);
        `CHK("rd_ack", a, ack)
        if (a) `CHK("rd_data", d, rd)
    endtask
    task automatic vin_step(input logic [15:0] v, input logic e);
        @(posedge clk_sys_in);
        vin_meas_in <= v;
        repeat (5) @(posedge clk_sys_in);
        #1;
        `CHK("vin_oen", e, oen)
    endtask
    task automatic run_fault(input logic [7:0] act, input int n, rlo, rhi, llo, lhi);
        int r0;
        int l0;
        wr_reg(CMD_OV_ACTION, {8'h00, act}, 1'b1);
        @(posedge clk_sys_in);
        clear_faults_in <= 1'b1;
        @(posedge clk_sys_in);
        clear_faults_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        r0 = rises;
        l0 = lows;
        vout_meas_in <= 16'h3000;
        repeat (n) @(posedge clk_sys_in);
        vout_meas_in <= 16'h1000;
        #1;
        `CHK("flag", 1'b1, flag)
        `CHK("restarts", 1'b1, rises - r0 >= rlo && rises - r0 <= rhi)
        `CHK("off_cycles", 1'b1, lows - l0 >= llo && lows - l0 <= lhi)
    endtask
    // ==========================
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_link_in);
        rst_link_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rd_chk(CMD_OV_LIMIT, 1'b1, RST_OV_LIMIT);
        rd_chk(CMD_OV_ACTION, 1'b1, {8'h00, RST_OV_ACTION});
        rd_chk(CMD_TIME_UNIT, 1'b1, RST_TIME_UNIT);
        foreach (rows[i])
        begin
            wr_reg(rows[i].c, rows[i].d, rows[i].a);
            rd_chk(rows[i].c, rows[i].a, rows[i].d);
        end
        wr_reg(CMD_OUT_FORMAT, 16'h0000, 1'b0);
        rd_chk(CMD_OUT_FORMAT, 1'b1, 16'h0015);
        wr_reg(CMD_OV_ACTION, 16'hff9b, 1'b1);
        rd_chk(CMD_OV_ACTION, 1'b1, 16'h009b);
        `CHK("duty", 16'h1234, duty)
        `CHK("freq", 16'h0190, freq)
        `CHK("phase", 12'ha53, phase)
        `CHK("current", 16'hf80f, cur)
        vin_step(16'h0081, 1'b1);
        vin_step(16'h0080, 1'b0);
        vin_step(16'h00ff, 1'b0);
        vin_step(16'h0100, 1'b1);
        vin_step(16'h0200, 1'b1);
        run_fault(8'h00, 40, 0, 0, 0, 0);
        run_fault(8'h80, 40, 0, 0, 36, 41);
        run_fault(8'h93, 120, 2, 2, 105, 121);
        run_fault(8'h93, 120, 2, 2, 105, 121);
        run_fault(8'h8d, 25, 0, 0, 0, 200);
        run_fault(8'h8d, 45, 1, 1, 0, 200);
        wr_reg(CMD_TIME_UNIT, 16'h0002, 1'b1);
        run_fault(8'h8d, 45, 0, 0, 0, 200);
        wr_reg(CMD_TIME_UNIT, 16'h0001, 1'b1);
        run_fault(8'hb8, 60, 8, 40, 0, 61);
        run_fault(8'h44, 40, 0, 0, 18, 26);
        run_fault(8'hc0, 30, 0, 0, 25, 31);
        repeat (5) @(posedge clk_sys_in);
        #1;
        `CHK("oen_resume", 1'b1, oen)
        for (int m = 0; m < 5; m++)
        begin
            run_fault(8'h80, 5, 0, 0, 1, 6);
            @(posedge clk_sys_in);
            clear_faults_in <= (m == 0);
            status_clear_in <= (m == 1);
            ctrl_pin_in <= (m != 2);
            operation_on_in <= (m != 3);
            rst_in <= (m == 4);
            repeat (4) @(posedge clk_sys_in);
            clear_faults_in <= 1'b0;
            status_clear_in <= 1'b0;
            ctrl_pin_in <= 1'b1;
            operation_on_in <= 1'b1;
            rst_in <= 1'b0;
            repeat (10) @(posedge clk_sys_in);
            #1;
            `CHK("oen_back", 1'b1, oen)
            `CHK("flag_clear", 1'b0, flag)
        end
        // enable low freezes state: an off pin pulse must go unseen
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        ctrl_pin_in <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1;
        `CHK("oen_frozen", 1'b1, oen)
        @(posedge clk_sys_in);
        ctrl_pin_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        ce_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        #1;
        `CHK("oen_thawed", 1'b1, oen)
        give_verdict();
    end
endmodule
